// ### ahb_lite_port.sv
`timescale 1ns/1ps
// ==========================================
// ahb-lite slave: zero-wait writes, one wait state on reads
module ahb_lite_port
   import i2c_ss_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic wr_stb,
   output logic rd_stb,
   output logic [i2c_ss_pkg::ADDR_W-1:0] acc_addr,
   output logic [7:0] wdata,
   input wire logic [7:0] rdata_in
);
   logic wr_pend_r;
   logic rd_pend_r;
   logic [ADDR_W-1:0] addr_r;
   logic [31:0] hrdata_r;
   logic take;

   // only whole-word singles are used, so hsize needs no decode
   assign take = hsel & hready & htrans[1];

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r <= '0;
      end else begin
         wr_pend_r <= take & hwrite;
         rd_pend_r <= take & ~hwrite;
         if (take) begin
            addr_r <= haddr[ADDR_W-1:0];
         end
      end
   end

   // read data is registered; the wait state keeps hrdata off a comb path
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         hrdata_r <= 32'h0;
      end else if (rd_pend_r) begin
         hrdata_r <= {24'h0, rdata_in};
      end
   end

   assign hreadyout = ~rd_pend_r;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;
   assign wr_stb = wr_pend_r;
   assign rd_stb = rd_pend_r;
   assign acc_addr = addr_r;
   assign wdata = hwdata[7:0];
endmodule

// ### i2c_master_model.sv
`timescale 1ns/1ps
// ==========================================
// behavioural i2c master; open drain, so it only ever pulls a line low
module i2c_master_model (
   input wire logic scl,
   input wire logic sda,
   output logic scl_oe,
   output logic sda_oe
);
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end
   // sda falls while scl is high; only the master opens a frame
   task automatic start();
      sda_oe = 1'b1;
      #40 scl_oe = 1'b1;
   endtask
   // one clock; sda changes well after the fall so the slave never sees a false start
   task automatic bit_io(input logic b, output logic r);
      #30 sda_oe = ~b;
      #10 scl_oe = 1'b0;
      // the slave may stretch the low phase, so wait bounded for scl high
      for (int i = 0; i < 2000 && scl !== 1'b1; i++) #10;
      #35 r = sda;
      #5 scl_oe = 1'b1;
   endtask
   // eight bits msb first, then the acknowledge clock
   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                       output logic ack_out);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(ack_in, ack_out);
   endtask
   // sda rises while scl is high
   task automatic stop();
      #30 sda_oe = 1'b1;
      #10 scl_oe = 1'b0;
      #40 sda_oe = 1'b0;
      #80;
   endtask
endmodule

// ### i2c_slave_status_control.sv
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
// ==========================================
// i2c slave with status and control register behind ahb-lite
module i2c_slave_status_control
   import i2c_ss_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic timeout_event,
   input wire logic low_power,
   output logic irq,
   output logic wakeup
);
   // ==========================================
   // wiring
   logic scl_s, sda_s, scl_rise, scl_fall, sda_rise, sda_fall;
   logic wr_stb, rd_stb;
   logic [ADDR_W-1:0] acc_addr;
   logic [7:0] wdata;
   logic [7:0] rdata;

   logic en_r, done_r, match_r, busy_r, dir_r, acks_r, rw_r, wake_en_r, ackrx_r;
   logic tout_r, irq_r, wakeup_r, sda_oe_r, scl_oe_r;
   logic [7:0] own_r, data_r, shift_r;
   logic [3:0] bitcnt_r;
   bus_state_t state_r;

   pin_sync u_sync (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .scl_s(scl_s),
      .sda_s(sda_s),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .sda_rise(sda_rise),
      .sda_fall(sda_fall)
   );

   ahb_lite_port u_ahb (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .wr_stb(wr_stb),
      .rd_stb(rd_stb),
      .acc_addr(acc_addr),
      .wdata(wdata),
      .rdata_in(rdata)
   );

   // ==========================================
   // register decode
   logic wr_ctrl, wr_own, wr_stat, wr_data, wr_tout, rd_data_buf, en_rise;
   assign wr_ctrl = wr_stb & (acc_addr == REG_CTRL_OFS);
   assign wr_own = wr_stb & (acc_addr == REG_OWN_OFS);
   assign wr_stat = wr_stb & (acc_addr == REG_STAT_OFS);
   assign wr_data = wr_stb & (acc_addr == REG_DATA_OFS);
   assign wr_tout = wr_stb & (acc_addr == REG_TOUT_OFS);
   assign rd_data_buf = rd_stb & (acc_addr == REG_DATA_OFS);
   assign en_rise = wr_ctrl & wdata[CTRL_EN_BIT] & ~en_r;

   logic [7:0] stat_view;
   assign stat_view = {done_r, match_r, busy_r, dir_r, acks_r, rw_r, wake_en_r, ackrx_r};

   // unmapped addresses read as zero and ignore writes
   assign rdata = (acc_addr == REG_CTRL_OFS) ? {7'h0, en_r} :
                  (acc_addr == REG_OWN_OFS) ? (own_r & OWN_ADDR_MASK) :
                  (acc_addr == REG_STAT_OFS) ? stat_view :
                  (acc_addr == REG_DATA_OFS) ? data_r :
                  (acc_addr == REG_TOUT_OFS) ? {7'h0, tout_r} : 8'h00;

   // ==========================================
   // link events
   logic start_det, stop_det, tout_hit, ev_ok;
   logic hit, rx_done, tx_done, tx_ack_smp, byte_evt, release_sw;
   assign start_det = en_r & scl_s & sda_fall;
   assign stop_det = en_r & scl_s & sda_rise;
   assign tout_hit = en_r & timeout_event;
   assign ev_ok = en_r & ~start_det & ~stop_det & ~tout_hit;
   // seven address bits sit in shift_r[6:0]; sda now holds the r/w bit
   assign hit = ev_ok & (state_r == st_addr) & scl_rise & (bitcnt_r == BIT_LAST)
                & (shift_r[6:0] == own_r[7:1]);
   assign rx_done = ev_ok & (state_r == st_rx) & scl_rise & (bitcnt_r == BIT_LAST);
   assign tx_done = ev_ok & (state_r == st_tx) & scl_rise & (bitcnt_r == BIT_LAST);
   assign tx_ack_smp = ev_ok & (state_r == st_tx_ack) & scl_rise;
   assign byte_evt = rx_done | tx_done;
   assign release_sw = ev_ok & (state_r == st_hold)
                       & ((dir_r & wr_data) | (~dir_r & rd_data_buf));

   // ==========================================
   // control and configuration
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         en_r <= 1'b0;
         own_r <= OWN_POR;
      end else begin
         if (wr_ctrl) en_r <= wdata[CTRL_EN_BIT];
         if (wr_own) own_r <= wdata & OWN_ADDR_MASK;
      end
   end

   // time-out flag: the set wins over a software clear in the same cycle
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tout_r <= 1'b0;
      end else if (tout_hit) begin
         tout_r <= 1'b1;
      end else if (wr_tout & ~wdata[TOUT_FLAG_BIT]) begin
         tout_r <= 1'b0;
      end
   end

   // ==========================================
   // status flags; a time-out returns the whole register to its reset value
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         {done_r, match_r, busy_r, dir_r, acks_r, rw_r, wake_en_r, ackrx_r} <= STAT_POR;
      end else if (tout_hit) begin
         {done_r, match_r, busy_r, dir_r, acks_r, rw_r, wake_en_r, ackrx_r} <= STAT_POR;
      end else begin
         if (en_rise) begin
            // direction, ack-send and wake-enable bits keep what software left there
            done_r <= STAT_POR[ST_DONE_BIT];
            match_r <= STAT_POR[ST_MATCH_BIT];
            busy_r <= STAT_POR[ST_BUSY_BIT];
            rw_r <= STAT_POR[ST_RW_BIT];
            ackrx_r <= STAT_POR[ST_ACKRX_BIT];
         end else begin
            if (byte_evt | stop_det) done_r <= 1'b1;
            else if (start_det | rd_data_buf) done_r <= 1'b0;
            if (hit) match_r <= 1'b1;
            else if (start_det | stop_det) match_r <= 1'b0;
            if (start_det) busy_r <= 1'b1;
            else if (stop_det | ~en_r) busy_r <= 1'b0;
            if (hit) rw_r <= sda_s;
            if (tx_ack_smp) ackrx_r <= sda_s;
         end
         if (wr_stat) begin
            dir_r <= wdata[ST_DIR_BIT];
            acks_r <= wdata[ST_ACKS_BIT];
            wake_en_r <= wdata[ST_WAKE_BIT];
         end
      end
   end

   // ==========================================
   // data buffer: software writes it, a received byte overwrites it
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         data_r <= 8'h00;
      end else if (rx_done) begin
         data_r <= {shift_r[6:0], sda_s};
      end else if (wr_data) begin
         data_r <= wdata;
      end
   end

   // ==========================================
   // interrupt and wake-up pulses, one cycle each
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irq_r <= 1'b0;
         wakeup_r <= 1'b0;
      end else begin
         irq_r <= hit | byte_evt | tout_hit;
         wakeup_r <= hit & wake_en_r & low_power;
      end
   end

   // ==========================================
   // serial engine; the slave only ever pulls lines low, never makes a START
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= st_idle;
         shift_r <= 8'h00;
         bitcnt_r <= 4'h0;
         sda_oe_r <= 1'b0;
         scl_oe_r <= 1'b0;
      end else if (!en_r || tout_hit || stop_det) begin
         state_r <= st_idle;
         sda_oe_r <= 1'b0;
         scl_oe_r <= 1'b0;
      end else if (start_det) begin
         state_r <= st_addr;
         bitcnt_r <= 4'h0;
         sda_oe_r <= 1'b0;
         scl_oe_r <= 1'b0;
      end else begin
         case (state_r)
            st_addr: begin
               if (scl_rise) begin
                  shift_r <= {shift_r[6:0], sda_s};
                  bitcnt_r <= (bitcnt_r == BIT_LAST) ? ACK_DRIVE : bitcnt_r + 4'h1;
                  if (bitcnt_r == BIT_LAST) state_r <= hit ? st_addr_ack : st_ignore;
               end
            end
            st_addr_ack: begin
               if (scl_fall && bitcnt_r == ACK_DRIVE) begin
                  sda_oe_r <= 1'b1;
                  bitcnt_r <= ACK_END;
               end else if (scl_fall) begin
                  sda_oe_r <= 1'b0;
                  scl_oe_r <= 1'b1;
                  bitcnt_r <= 4'h0;
                  state_r <= st_hold;
               end
            end
            st_hold: begin
               if (release_sw) begin
                  scl_oe_r <= 1'b0;
                  if (dir_r) begin
                     shift_r <= wdata;
                     sda_oe_r <= ~wdata[7];
                     state_r <= st_tx;
                  end else begin
                     state_r <= st_rx;
                  end
               end
            end
            st_rx: begin
               if (scl_rise) begin
                  shift_r <= {shift_r[6:0], sda_s};
                  bitcnt_r <= (bitcnt_r == BIT_LAST) ? ACK_DRIVE : bitcnt_r + 4'h1;
                  if (bitcnt_r == BIT_LAST) state_r <= st_rx_ack;
               end
            end
            st_rx_ack: begin
               if (scl_fall && bitcnt_r == ACK_DRIVE) begin
                  sda_oe_r <= ~acks_r;
                  bitcnt_r <= ACK_END;
               end else if (scl_fall) begin
                  sda_oe_r <= 1'b0;
                  bitcnt_r <= 4'h0;
                  state_r <= st_rx;
               end
            end
            st_tx: begin
               if (scl_rise) begin
                  bitcnt_r <= bitcnt_r + 4'h1;
               end else if (scl_fall && bitcnt_r == BIT_PAST) begin
                  sda_oe_r <= 1'b0; // line free for the master's ack
                  bitcnt_r <= 4'h0;
                  state_r <= st_tx_ack;
               end else if (scl_fall) begin
                  shift_r <= {shift_r[6:0], 1'b0};
                  sda_oe_r <= ~shift_r[6];
               end
            end
            st_tx_ack: begin
               // a missing ack ends sending until the master's next START or STOP
               if (scl_rise && sda_s) begin
                  state_r <= st_ignore;
               end else if (scl_fall) begin
                  shift_r <= data_r;
                  sda_oe_r <= ~data_r[7];
                  state_r <= st_tx;
               end
            end
            st_ignore: begin
               sda_oe_r <= 1'b0;
               scl_oe_r <= 1'b0;
            end
            default: begin
               state_r <= st_idle;
            end
         endcase
      end
   end

   // ==========================================
   // pins and outputs; open-drain, so the driven level is always low
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = scl_oe_r;
   assign sda_oe = sda_oe_r;
   assign irq = irq_r;
   assign wakeup = wakeup_r;

   // ==========================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   a_start_sets_busy: assert property (start_det && !tout_hit |=> busy_r && !done_r)
      else $error("start did not set busy and clear byte done");
   a_stop_frees_bus: assert property (stop_det && !tout_hit |=> !busy_r && done_r)
      else $error("stop did not clear busy and set byte done");
   a_byte_done_irq: assert property (byte_evt && !tout_hit |=> done_r && irq)
      else $error("byte completion missed flag or interrupt");
   a_read_clears_done: assert property (rd_data_buf && !byte_evt && !stop_det && !tout_hit
      |=> !done_r)
      else $error("data read did not clear byte done");
   a_match_ack_low: assert property (ev_ok && state_r == st_addr_ack && bitcnt_r == ACK_DRIVE
      && scl_fall |=> sda_oe_r)
      else $error("address match not acknowledged");
   a_rw_capture: assert property (hit |=> match_r && rw_r == $past(sda_s))
      else $error("read write bit not captured on match");
   a_rx_ack_level: assert property (ev_ok && state_r == st_rx_ack && bitcnt_r == ACK_DRIVE
      && scl_fall |=> sda_oe_r == !$past(acks_r))
      else $error("ack level differs from ack send bit");
   a_nack_release: assert property (tx_ack_smp && sda_s
      |=> ackrx_r && state_r == st_ignore ##1 !sda_oe_r)
      else $error("transmitter kept going after nack");
   a_hold_scl: assert property (state_r == st_hold |-> scl_oe_r && !sda_oe_r)
      else $error("scl not held after match");
   a_no_match_quiet: assert property (state_r == st_ignore && $past(state_r) == st_ignore
      |-> !sda_oe_r && !scl_oe_r)
      else $error("pins driven without a match");
endmodule

// ### i2c_slave_status_control_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
   $display("[FAIL] %s expected %h seen %h", n, e, g); end end
// ==========================================
// self-checking bench: ahb-lite master tasks plus an i2c master model
module i2c_slave_status_control_test;
   import i2c_ss_pkg::*;
   localparam logic [6:0] OWN7 = 7'h5a;
   logic sys_clk, nrst, hsel, hwrite, hready, hreadyout, hresp, timeout_event, low_power;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic scl_oe, sda_oe, m_scl_oe, m_sda_oe, irq, wakeup, scl, sda, ack;
   logic [7:0] q8;
   int err_count = 0, samples_checked = 0, irq_n = 0, wake_n = 0;
   // pull-ups: a line is high unless someone pulls it
   assign scl = ~(scl_oe | m_scl_oe);
   assign sda = ~(sda_oe | m_sda_oe);
   assign hready = hreadyout;
   i2c_slave_status_control dut (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scl_in(scl), .scl_out(),
      .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
      .timeout_event(timeout_event), .low_power(low_power), .irq(irq), .wakeup(wakeup));
   i2c_master_model m (.scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // pulse counters for interrupt and wake-up
   always @(posedge sys_clk) begin
      if (irq === 1'b1) irq_n++;
      if (wakeup === 1'b1) wake_n++;
   end
   // ==========================================
   // one single ahb transfer; waits for hready in both phases
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      q8 = hrdata[7:0];
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      `CHK("register read", e, q8 & mask)
   endtask
   task automatic clks(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // ==========================================
   task automatic test_regs();
      rd(REG_STAT_OFS, 8'hff, 8'h81);
      rd(REG_OWN_OFS, 8'hff, 8'h00);
      rd(8'h20, 8'hff, 8'h00);
      bus(1'b1, REG_STAT_OFS, 8'hff);
      rd(REG_STAT_OFS, 8'hff, 8'h9b);
      bus(1'b1, REG_STAT_OFS, 8'h00);
      bus(1'b1, REG_OWN_OFS, {OWN7, 1'b1});
      rd(REG_OWN_OFS, 8'hff, {OWN7, 1'b0});
      bus(1'b1, REG_CTRL_OFS, 8'h01);
      $display("test regs done");
   endtask
   // master writes two bytes; wake-up armed while in low power
   task automatic test_write();
      bus(1'b1, REG_STAT_OFS, 8'h02);
      low_power <= 1'b1;
      irq_n = 0;
      m.start();
      rd(REG_STAT_OFS, 8'ha0, 8'h20);
      m.xfer({OWN7, 1'b0}, 1'b1, q8, ack);
      `CHK("address ack", 1'b0, ack)
      `CHK("irq on match", 1, irq_n)
      `CHK("wakeup", 1, wake_n)
      clks(20);
      `CHK("scl held", 1'b1, scl_oe)
      rd(REG_STAT_OFS, 8'h46, 8'h42);
      low_power <= 1'b0;
      // receive mode: only a dummy read of the data buffer lets scl go
      rd(REG_DATA_OFS, 8'hff, 8'h00);
      clks(10);
      `CHK("scl freed", 1'b0, scl_oe)
      m.xfer(8'hc3, 1'b1, q8, ack);
      `CHK("data ack", 1'b0, ack)
      `CHK("irq on byte", 2, irq_n)
      rd(REG_STAT_OFS, 8'h80, 8'h80);
      rd(REG_DATA_OFS, 8'hff, 8'hc3);
      rd(REG_STAT_OFS, 8'h80, 8'h00);
      bus(1'b1, REG_STAT_OFS, 8'h08);
      m.xfer(8'h5a, 1'b1, q8, ack);
      `CHK("data nack", 1'b1, ack)
      m.stop();
      rd(REG_STAT_OFS, 8'ha0, 8'h80);
      $display("test write done");
   endtask
   // a foreign address is ignored
   task automatic test_nomatch();
      bus(1'b1, REG_STAT_OFS, 8'h00);
      m.start();
      m.xfer({OWN7 ^ 7'h01, 1'b0}, 1'b1, q8, ack);
      `CHK("foreign ack", 1'b1, ack)
      rd(REG_STAT_OFS, 8'h60, 8'h20);
      m.stop();
      rd(REG_STAT_OFS, 8'h20, 8'h00);
      $display("test nomatch done");
   endtask
   // master reads twice, acks the first, refuses the second
   task automatic test_read();
      m.start();
      m.xfer({OWN7, 1'b1}, 1'b1, q8, ack);
      `CHK("read address ack", 1'b0, ack)
      rd(REG_STAT_OFS, 8'h04, 8'h04);
      bus(1'b1, REG_STAT_OFS, 8'h10);
      bus(1'b1, REG_DATA_OFS, 8'ha5);
      m.xfer(8'hff, 1'b0, q8, ack);
      `CHK("sent byte", 8'ha5, q8)
      rd(REG_STAT_OFS, 8'h01, 8'h00);
      m.xfer(8'hff, 1'b1, q8, ack);
      `CHK("second byte", 8'ha5, q8)
      rd(REG_STAT_OFS, 8'h81, 8'h81);
      bus(1'b1, REG_DATA_OFS, 8'h00);
      clks(20);
      `CHK("sda freed", 1'b0, sda_oe)
      m.stop();
      $display("test read done");
   endtask
   // re-enable keeps control bits; time-out restores the reset state
   task automatic test_enable_timeout();
      bus(1'b1, REG_STAT_OFS, 8'h18);
      bus(1'b1, REG_CTRL_OFS, 8'h00);
      bus(1'b1, REG_CTRL_OFS, 8'h01);
      rd(REG_STAT_OFS, 8'hff, 8'h99);
      irq_n = 0;
      timeout_event <= 1'b1;
      clks(1);
      timeout_event <= 1'b0;
      clks(2);
      `CHK("irq on timeout", 1, irq_n)
      rd(REG_STAT_OFS, 8'hff, 8'h81);
      rd(REG_TOUT_OFS, 8'hff, 8'h01);
      bus(1'b1, REG_TOUT_OFS, 8'h00);
      rd(REG_TOUT_OFS, 8'hff, 8'h00);
      $display("test enable timeout done");
   endtask
   // ==========================================
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // the whole run needs under ten microseconds
   initial begin
      #300000;
      err_count++;
      end_of_test();
   end
   initial begin
      {nrst, hsel, hwrite, timeout_event, low_power} = 5'h00;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'b00;
      hsize = 3'b010;
      clks(16);
      nrst <= 1'b1;
      test_regs();
      test_write();
      test_nomatch();
      test_read();
      test_enable_timeout();
      end_of_test();
   end
endmodule

// ### i2c_ss_pkg.sv
// What this block does
// - byte_done_flag low while a byte moves, high with an interrupt after eight bits.
// - a START clears byte_done_flag.
// - a software read of bus_data_buffer clears byte_done_flag until the next byte.
// - a STOP sets byte_done_flag.
// - address_matched_flag is high on an own-address match, low otherwise.
// - bus_busy_flag goes to 1 on START and to 0 on STOP.
// - direction_select 0 makes the slave receive, 1 makes it transmit.
// - after eight received bits, ack_send_bit is driven onto SDA on the ninth clock.
// - the bit after the seven address bits is captured into read_write_flag.
// - after eight sent bits, SDA on the ninth clock goes into ack_received_flag.
// - on a missing acknowledge the transmitter stops and releases SDA.
// - after START, seven address bits arrive MSB first and are compared.
// - match, byte completion and time-out share one interrupt output.
// - on an address match SDA is driven low during the ninth bit.
// - START is SDA falling while SCL stays high.
// - after a match SCL is held low until a data write or dummy read.
// - with match_wakeup_enable set, an address match wakes the device.
// - own address is bits 7 to 1 of own_address_reg; bit 0 is ignored.
// - enabling the interface resets status flags but keeps direction and ack bits.
package i2c_ss_pkg;
   // ==========================================
   // register map, byte addresses on the bus
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] REG_CTRL_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] REG_OWN_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] REG_STAT_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] REG_DATA_OFS = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_TOUT_OFS = 8'h10;
   // ==========================================
   // field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int TOUT_FLAG_BIT = 0;
   localparam int ST_DONE_BIT = 7;
   localparam int ST_MATCH_BIT = 6;
   localparam int ST_BUSY_BIT = 5;
   localparam int ST_DIR_BIT = 4;
   localparam int ST_ACKS_BIT = 3;
   localparam int ST_RW_BIT = 2;
   localparam int ST_WAKE_BIT = 1;
   localparam int ST_ACKRX_BIT = 0;
   localparam logic [7:0] OWN_ADDR_MASK = 8'hfe;
   // ==========================================
   // reset values
   localparam logic [7:0] STAT_POR = 8'h81;
   localparam logic [7:0] OWN_POR = 8'h00;
   // ==========================================
   // bit counting on the serial link
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_PAST = 4'h8;
   localparam logic [3:0] ACK_DRIVE = 4'h0;
   localparam logic [3:0] ACK_END = 4'h1;
   typedef enum logic [3:0] {
      st_idle, st_addr, st_addr_ack, st_hold, st_rx, st_rx_ack, st_tx, st_tx_ack, st_ignore
   } bus_state_t;
endpackage

// ### pin_sync.sv
`timescale 1ns/1ps
// ==========================================
// two-stage synchroniser and edge finder for scl and sda
module pin_sync (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_s,
   output logic sda_s,
   output logic scl_rise,
   output logic scl_fall,
   output logic sda_rise,
   output logic sda_fall
);
   logic [1:0] meta_r;
   logic [1:0] sync_r;
   logic [1:0] prev_r;

   // pins idle high, so reset to high avoids false edges at release
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         meta_r <= 2'h3;
         sync_r <= 2'h3;
         prev_r <= 2'h3;
      end else begin
         meta_r <= {scl_in, sda_in};
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   // edges look only at the second and third stages
   assign scl_s = sync_r[1];
   assign sda_s = sync_r[0];
   assign scl_rise = sync_r[1] & ~prev_r[1];
   assign scl_fall = ~sync_r[1] & prev_r[1];
   assign sda_rise = sync_r[0] & ~prev_r[0];
   assign sda_fall = ~sync_r[0] & prev_r[0];
endmodule
